/* File: hw/dtd_top.sv */
// Data-transfer instruction timing engine with float, mode and address limits.
`timescale 1ns/1ps
// How it works
// RULE1: Float request tri-states all outputs, hold acknowledge too.
// RULE2: Comes out of reset in protected mode.
// RULE3: Segmentation only maps 48-bit to 24-bit.
// RULE4: Virtual task mode requests are never honoured.
// RULE5: Only 32-bit code segments are executed.
// RULE6: Two-register address adds one clock.
// RULE7: Misaligned or even 32-bit adds 2/4.
// RULE8: Odd 32-bit operand adds 4/8 clocks.
// RULE9: Each wait state adds one clock.
// RULE10: Register form smaller count, memory larger.
// RULE11: Store register move takes 2 clocks.
// RULE12: Load register move takes 2/4 clocks.
// RULE13: Immediate to register short form, 2 clocks.
// RULE14: Accumulator store takes 2 clocks, one cycle.
// RULE15: Segment load takes 22 or 23 clocks.
// RULE16: Sign and zero extension take 3/6.
// RULE17: Segment push takes 4 clocks, 2 cycles.
// RULE18: Segment pop takes 25 clocks, 6 cycles.
// RULE19: Exchange takes 3 or 5 clocks.
// RULE20: Fixed port input takes 6 or 26.
// RULE21: Fixed port output takes 4 or 24.
// RULE22: Effective address load takes 2, no data.
// RULE23: Width bit clear selects byte operand.
module dtd_top (
    input  wire logic                CLK,
    input  wire logic                RSTN,
    input  wire logic                FLOAT_REQUEST,
    input  wire logic                HOLD_ACK_INT,
    input  wire logic                ISSUE,
    input  dtd_pkg::dtd_instr_t      INSTR,
    input  wire logic [15:0]         SEL,
    input  wire logic [31:0]         OFFSET,
    input  wire logic [23:0]         SEG_BASE,
    input  wire logic                WAIT_STATE,
    output logic                     READY,
    output logic                     DONE,
    output logic                     FAULT,
    output logic                     PROTECTED_MODE,
    output logic [5:0]               CLOCKS_USED,
    output logic [2:0]               DATA_CYCLES,
    output logic [23:0]              PHYS_ADDR,
    output logic                     PIN_OE,
    output logic                     HOLD_ACKNOWLEDGE,
    output logic                     HOLD_ACKNOWLEDGE_OE
);
    // ==========================================================================
    // Pin synchroniser
    // ==========================================================================
    logic float_meta;
    logic float_sync;
    logic next_float_meta;
    logic next_float_sync;
    always_comb begin
        next_float_meta = FLOAT_REQUEST;
        next_float_sync = float_meta;
    end
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            float_meta <= 1'b0;
            float_sync <= 1'b0;
        end else begin
            float_meta <= next_float_meta;
            float_sync <= next_float_sync;
        end
    end

    // ==========================================================================
    // Decode and penalties
    // ==========================================================================
    dtd_pkg::dtd_decode_t dec;
    dtd_decode u_decode (
        .instr (INSTR),
        .dec   (dec)
    );

    function automatic logic [5:0] align_penalty(input dtd_pkg::dtd_size_t sz,
                                                 input logic odd,
                                                 input logic rmw);
        logic [5:0] p;
        p = 6'h00;
        if (sz == dtd_pkg::DTD_SZ_DWORD && odd) begin
            p = rmw ? dtd_pkg::CLK_ODD_RMW : dtd_pkg::CLK_ODD_RW; // RULE8
        end else if (sz == dtd_pkg::DTD_SZ_DWORD || (sz == dtd_pkg::DTD_SZ_WORD && odd)) begin
            p = rmw ? dtd_pkg::CLK_MIS_RMW : dtd_pkg::CLK_MIS_RW; // RULE7
        end
        return p;
    endfunction : align_penalty

    logic       illegal;
    logic       ea_load;
    logic [5:0] total;
    always_comb begin
        illegal = !dec.legal || INSTR.want_v86 || INSTR.code16; // RULE4 RULE5
        // The address load computes an address too, so two base registers cost it a clock.
        ea_load = (INSTR.first == dtd_pkg::OP_EA_LOAD) &&
                  (INSTR.second[7:6] != dtd_pkg::MOD_REG);
        total   = dec.base_clocks;
        if ((dec.is_mem || ea_load) && INSTR.two_reg_ea) begin
            total = total + dtd_pkg::CLK_TWO_REG; // RULE6
        end
        // A byte operand can never straddle a word, whatever size the bus side reports.
        if (dec.is_mem) begin
            total = total + align_penalty(dec.full_width ? INSTR.size : dtd_pkg::DTD_SZ_BYTE,
                                          INSTR.odd_addr, dec.is_rmw); // RULE23
        end
    end

    // ==========================================================================
    // Execution timer
    // ==========================================================================
    typedef enum logic [1:0] {DTD_IDLE, DTD_RUN, DTD_WAITS} dtd_state_t;
    dtd_state_t state;
    dtd_state_t next_state;
    logic [5:0]  remain;
    logic [5:0]  next_remain;
    logic [5:0]  used;
    logic [5:0]  next_used;
    logic [2:0]  cycles;
    logic [2:0]  next_cycles;
    logic [2:0]  cyc_pend;
    logic [2:0]  next_cyc_pend;
    logic        done;
    logic        next_done;
    logic        fault;
    logic        next_fault;
    logic [23:0] phys;
    logic [23:0] next_phys;
    logic        prot;
    logic        next_prot;

    always_comb begin
        next_state    = state;
        next_remain   = remain;
        next_used     = used;
        next_cycles   = cycles;
        next_cyc_pend = cyc_pend;
        next_done     = 1'b0;
        next_fault    = 1'b0;
        next_phys     = phys;
        next_prot     = 1'b1; // RULE2
        case (state)
            DTD_IDLE: begin
                if (ISSUE && !float_sync) begin
                    if (illegal) begin
                        next_fault = 1'b1;
                    end else begin
                        // Segment base plus offset, truncated; no page stage follows.
                        next_phys     = SEG_BASE + OFFSET[23:0]; // RULE3
                        next_remain   = total;
                        next_used     = 6'h01;
                        next_cycles   = dec.data_cycles;
                        next_cyc_pend = dec.data_cycles;
                        next_state    = (total > 6'h01) ? DTD_RUN : DTD_WAITS;
                        if (total <= 6'h01 && (dec.data_cycles == 3'h0 || !WAIT_STATE)) begin
                            next_done  = 1'b1;
                            next_state = DTD_IDLE;
                        end
                    end
                end
            end
            DTD_RUN: begin
                next_used = used + 6'h01;
                if (WAIT_STATE && cyc_pend != 3'h0) begin
                    next_used = used + 6'h01; // RULE9
                end else begin
                    next_remain = remain - 6'h01;
                    if (remain == 6'h02) begin
                        next_done  = 1'b1;
                        next_state = DTD_IDLE;
                    end
                end
            end
            DTD_WAITS: begin
                next_used = used + 6'h01;
                if (!WAIT_STATE) begin
                    next_done  = 1'b1;
                    next_state = DTD_IDLE;
                end
            end
            default: begin
                next_state = DTD_IDLE;
            end
        endcase
        if (state != DTD_IDLE && SEL[0] && cyc_pend != 3'h0 && !WAIT_STATE) begin
            next_cyc_pend = cyc_pend - 3'h1;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state    <= DTD_IDLE;
            remain   <= dtd_pkg::RESET_COUNT;
            used     <= dtd_pkg::RESET_COUNT;
            cycles   <= 3'h0;
            cyc_pend <= 3'h0;
            done     <= 1'b0;
            fault    <= 1'b0;
            phys     <= 24'h000000;
            prot     <= 1'b1;
        end else begin
            state    <= next_state;
            remain   <= next_remain;
            used     <= next_used;
            cycles   <= next_cycles;
            cyc_pend <= next_cyc_pend;
            done     <= next_done;
            fault    <= next_fault;
            phys     <= next_phys;
            prot     <= next_prot;
        end
    end

    // ==========================================================================
    // Outputs
    // ==========================================================================
    // Outputs keep their values under float; READY and the enables drop.
    always_comb begin
        READY               = (state == DTD_IDLE) && !float_sync;
        DONE                = done;
        FAULT               = fault;
        PROTECTED_MODE      = prot;
        CLOCKS_USED         = used;
        DATA_CYCLES         = cycles;
        PHYS_ADDR           = phys;
        PIN_OE              = !float_sync; // RULE1
        HOLD_ACKNOWLEDGE    = HOLD_ACK_INT;
        HOLD_ACKNOWLEDGE_OE = !float_sync; // RULE1
    end
endmodule : dtd_top

/* File: hw/dtd_pkg.sv */
// Package with opcodes, clock counts and carrier types of the data-transfer decoder.
package dtd_pkg;
    // ==========================================================================
    // Opcode patterns
    // ==========================================================================
    localparam logic [7:0] OP_ESCAPE    = 8'h0f;
    localparam logic [6:0] OP_MOV_RM_W  = 7'h44;
    localparam logic [6:0] OP_MOV_R_LD  = 7'h45;
    localparam logic [3:0] OP_MOV_IMM   = 4'hb;
    localparam logic [6:0] OP_ACC_ST    = 7'h51;
    localparam logic [7:0] OP_SEG_LD    = 8'h8e;
    localparam logic [6:0] OP_SIGN_EXT  = 7'h5f;
    localparam logic [6:0] OP_ZERO_EXT  = 7'h5b;
    localparam logic [6:0] OP_EXCHANGE  = 7'h43;
    localparam logic [6:0] OP_IN_FIXED  = 7'h72;
    localparam logic [6:0] OP_OUT_FIXED = 7'h73;
    localparam logic [7:0] OP_EA_LOAD   = 8'h8d;
    localparam logic [1:0] MOD_REG      = 2'h3;
    localparam logic [1:0] SEG_CODE     = 2'h1;
    // ==========================================================================
    // Clock counts and data cycles
    // ==========================================================================
    localparam logic [5:0] CLK_MOV_R    = 6'h02;
    localparam logic [5:0] CLK_MOV_LD_M = 6'h04;
    localparam logic [5:0] CLK_SEG_R    = 6'h16;
    localparam logic [5:0] CLK_SEG_M    = 6'h17;
    localparam logic [5:0] CLK_EXT_R    = 6'h03;
    localparam logic [5:0] CLK_EXT_M    = 6'h06;
    localparam logic [5:0] CLK_PUSH_SEG = 6'h04;
    localparam logic [5:0] CLK_POP_SEG  = 6'h19;
    localparam logic [5:0] CLK_XCH_R    = 6'h03;
    localparam logic [5:0] CLK_XCH_M    = 6'h05;
    localparam logic [5:0] CLK_IN_FAST  = 6'h06;
    localparam logic [5:0] CLK_IN_SLOW  = 6'h1a;
    localparam logic [5:0] CLK_OUT_FAST = 6'h04;
    localparam logic [5:0] CLK_OUT_SLOW = 6'h18;
    localparam logic [5:0] CLK_TWO_REG  = 6'h01;
    localparam logic [5:0] CLK_MIS_RW   = 6'h02;
    localparam logic [5:0] CLK_MIS_RMW  = 6'h04;
    localparam logic [5:0] CLK_ODD_RW   = 6'h04;
    localparam logic [5:0] CLK_ODD_RMW  = 6'h08;
    localparam logic [2:0] CYC_ONE      = 3'h1;
    localparam logic [2:0] CYC_TWO      = 3'h2;
    localparam logic [2:0] CYC_SIX      = 3'h6;
    localparam logic [5:0] RESET_COUNT  = 6'h00;
    // ==========================================================================
    // Carrier types
    // ==========================================================================
    typedef enum logic [1:0] {DTD_SZ_BYTE, DTD_SZ_WORD, DTD_SZ_DWORD} dtd_size_t;
    typedef struct packed {
        logic [7:0] first;
        logic [7:0] second;
        logic [7:0] third;
        logic       two_reg_ea;
        dtd_size_t  size;
        logic       odd_addr;
        logic       slow_io;
        logic       want_v86;
        logic       code16;
    } dtd_instr_t;
    typedef struct packed {
        logic       legal;
        logic       is_mem;
        logic       is_rmw;
        logic       full_width;
        logic [5:0] base_clocks;
        logic [2:0] data_cycles;
    } dtd_decode_t;
endpackage : dtd_pkg

/* File: hw/dtd_decode.sv */
// Combinational opcode decoder giving base clock count and data cycles.
`timescale 1ns/1ps
module dtd_decode (
    input  dtd_pkg::dtd_instr_t  instr,
    output dtd_pkg::dtd_decode_t dec
);
    logic [1:0] md;
    logic       mem;
    always_comb begin
        md  = instr.second[7:6];
        mem = (md != dtd_pkg::MOD_REG);
        dec = '0;
        dec.full_width = instr.first[0]; // RULE23
        if (instr.first[7:1] == dtd_pkg::OP_MOV_RM_W) begin
            dec.legal       = 1'b1;
            dec.is_mem      = mem;
            dec.base_clocks = dtd_pkg::CLK_MOV_R; // RULE11
            dec.data_cycles = mem ? dtd_pkg::CYC_ONE : 3'h0;
        end else if (instr.first[7:1] == dtd_pkg::OP_MOV_R_LD) begin
            dec.legal       = 1'b1;
            dec.is_mem      = mem;
            dec.base_clocks = mem ? dtd_pkg::CLK_MOV_LD_M : dtd_pkg::CLK_MOV_R; // RULE12 RULE10
            dec.data_cycles = mem ? dtd_pkg::CYC_ONE : 3'h0;
        end else if (instr.first[7:4] == dtd_pkg::OP_MOV_IMM) begin
            dec.legal       = 1'b1;
            dec.full_width  = instr.first[3]; // RULE13 RULE23
            dec.base_clocks = dtd_pkg::CLK_MOV_R;
        end else if (instr.first[7:1] == dtd_pkg::OP_ACC_ST) begin
            dec.legal       = 1'b1;
            dec.is_mem      = 1'b1;
            dec.base_clocks = dtd_pkg::CLK_MOV_R; // RULE14
            dec.data_cycles = dtd_pkg::CYC_ONE;
        end else if (instr.first == dtd_pkg::OP_SEG_LD) begin
            dec.legal       = 1'b1;
            dec.is_mem      = mem;
            dec.full_width  = 1'b1;
            dec.base_clocks = mem ? dtd_pkg::CLK_SEG_M : dtd_pkg::CLK_SEG_R; // RULE15
            dec.data_cycles = mem ? dtd_pkg::CYC_SIX : 3'h0;
        end else if (instr.first == dtd_pkg::OP_ESCAPE) begin
            if (instr.second[7:1] == dtd_pkg::OP_SIGN_EXT ||
                instr.second[7:1] == dtd_pkg::OP_ZERO_EXT) begin
                dec.legal       = 1'b1;
                dec.is_mem      = (instr.third[7:6] != dtd_pkg::MOD_REG);
                dec.full_width  = instr.second[0];
                dec.base_clocks = dec.is_mem ? dtd_pkg::CLK_EXT_M
                                             : dtd_pkg::CLK_EXT_R; // RULE16
                dec.data_cycles = dec.is_mem ? dtd_pkg::CYC_ONE : 3'h0;
            end
        end else if (instr.first[7:5] == 3'h0 && instr.first[2:1] == 2'h3) begin
            dec.full_width = 1'b1;
            if (!instr.first[0]) begin
                dec.legal       = 1'b1;
                dec.is_mem      = 1'b1;
                dec.base_clocks = dtd_pkg::CLK_PUSH_SEG; // RULE17
                dec.data_cycles = dtd_pkg::CYC_TWO;
            end else if (instr.first[4:3] != dtd_pkg::SEG_CODE) begin
                dec.legal       = 1'b1;
                dec.is_mem      = 1'b1;
                dec.base_clocks = dtd_pkg::CLK_POP_SEG; // RULE18
                dec.data_cycles = dtd_pkg::CYC_SIX;
            end
        end else if (instr.first[7:1] == dtd_pkg::OP_EXCHANGE) begin
            dec.legal       = 1'b1;
            dec.is_mem      = mem;
            dec.is_rmw      = mem;
            dec.base_clocks = mem ? dtd_pkg::CLK_XCH_M : dtd_pkg::CLK_XCH_R; // RULE19
            dec.data_cycles = mem ? dtd_pkg::CYC_TWO : 3'h0;
        end else if (instr.first[7:1] == dtd_pkg::OP_IN_FIXED) begin
            dec.legal       = 1'b1;
            dec.base_clocks = instr.slow_io ? dtd_pkg::CLK_IN_SLOW
                                            : dtd_pkg::CLK_IN_FAST; // RULE20
            dec.data_cycles = dtd_pkg::CYC_ONE;
        end else if (instr.first[7:1] == dtd_pkg::OP_OUT_FIXED) begin
            dec.legal       = 1'b1;
            dec.base_clocks = instr.slow_io ? dtd_pkg::CLK_OUT_SLOW
                                            : dtd_pkg::CLK_OUT_FAST; // RULE21
            dec.data_cycles = dtd_pkg::CYC_ONE;
        end else if (instr.first == dtd_pkg::OP_EA_LOAD) begin
            dec.legal       = 1'b1;
            dec.full_width  = 1'b1;
            dec.base_clocks = dtd_pkg::CLK_MOV_R; // RULE22
        end
    end
endmodule : dtd_decode

/* File: testbench/dtd_top_chk.sv */
// Concurrent checks on the ports of the data-transfer timing engine.
`timescale 1ns/1ps
module dtd_top_chk (
    input wire logic           CLK,
    input wire logic           RSTN,
    input wire logic           FLOAT_REQUEST,
    input wire logic           ISSUE,
    input dtd_pkg::dtd_instr_t INSTR,
    input wire logic [31:0]    OFFSET,
    input wire logic [23:0]    SEG_BASE,
    input wire logic           WAIT_STATE,
    input wire logic           READY,
    input wire logic           DONE,
    input wire logic           FAULT,
    input wire logic           PROTECTED_MODE,
    input wire logic [5:0]     CLOCKS_USED,
    input wire logic [2:0]     DATA_CYCLES,
    input wire logic [23:0]    PHYS_ADDR,
    input wire logic           PIN_OE,
    input wire logic           HOLD_ACKNOWLEDGE_OE
);
    // =========================================================================
    // Helpers
    // =========================================================================
    wire [23:0] want_phys = SEG_BASE + OFFSET[23:0];
    wire        take      = ISSUE && READY && !INSTR.want_v86 && !INSTR.code16;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // =========================================================================
    // Properties
    // =========================================================================
    // The float input passes two flops, so three sampled highs must have floated the pins.
    property p_float; FLOAT_REQUEST [*3] |-> !PIN_OE && !HOLD_ACKNOWLEDGE_OE; endproperty
    a_float: assert property (p_float) else $error("pins not floated");
    property p_unfloat; !FLOAT_REQUEST [*3] |-> PIN_OE && HOLD_ACKNOWLEDGE_OE; endproperty
    a_unfloat: assert property (p_unfloat) else $error("pins floated without request");
    property p_prot; PROTECTED_MODE; endproperty
    a_prot: assert property (p_prot) else $error("left protected mode");
    property p_phys; ISSUE && READY |=> FAULT || PHYS_ADDR == $past(want_phys); endproperty
    a_phys: assert property (p_phys) else $error("physical address wrong");
    property p_v86; ISSUE && READY && INSTR.want_v86 |=> FAULT && !DONE; endproperty
    a_v86: assert property (p_v86) else $error("v86 request honoured");
    property p_c16; ISSUE && READY && INSTR.code16 |=> FAULT && !DONE; endproperty
    a_c16: assert property (p_c16) else $error("16-bit code accepted");
    property p_two_reg;
        take && INSTR.first == 8'h89 && INSTR.second[7:6] != dtd_pkg::MOD_REG
        && INSTR.two_reg_ea && INSTR.size == dtd_pkg::DTD_SZ_BYTE ##1 !WAIT_STATE [*2]
        |-> ##1 DONE && CLOCKS_USED == 6'h03;
    endproperty
    a_two_reg: assert property (p_two_reg) else $error("two-register clock missing");
    property p_mov_rr;
        take && INSTR.first == 8'h89 && INSTR.second[7:6] == dtd_pkg::MOD_REG
        |=> !READY ##1 DONE && CLOCKS_USED == 6'h02;
    endproperty
    a_mov_rr: assert property (p_mov_rr) else $error("register move timing");
    property p_ea_load;
        take && INSTR.first == dtd_pkg::OP_EA_LOAD && !INSTR.two_reg_ea
        |=> ##1 DONE && CLOCKS_USED == 6'h02 && DATA_CYCLES == 3'h0;
    endproperty
    a_ea_load: assert property (p_ea_load) else $error("address load timing");
    property p_done_pulse; DONE |=> !DONE; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
endmodule : dtd_top_chk

bind dtd_top dtd_top_chk u_chk (.CLK, .RSTN, .FLOAT_REQUEST, .ISSUE, .INSTR, .OFFSET,
    .SEG_BASE, .WAIT_STATE, .READY, .DONE, .FAULT, .PROTECTED_MODE, .CLOCKS_USED,
    .DATA_CYCLES, .PHYS_ADDR, .PIN_OE, .HOLD_ACKNOWLEDGE_OE);

/* File: testbench/dtd_bus_model.sv */
// Local bus responder that inserts wait states and completes data cycles.
`timescale 1ns/1ps
module dtd_bus_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        busy,
    input  wire logic [3:0]  waits,
    output logic      [15:0] sel,
    output logic             wait_state
);
    // =========================================================================
    // Responder
    // =========================================================================
    logic [3:0] wcnt;
    // Each access is held off for the commanded number of wait clocks before it completes.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wcnt       <= 4'h0;
            sel        <= 16'h0000;
            wait_state <= 1'h0;
        end else if (busy && wcnt < waits) begin
            wcnt       <= wcnt + 4'h1;
            sel        <= 16'h0000;
            wait_state <= 1'h1;
        end else begin
            wcnt       <= 4'h0;
            sel        <= {15'h0000, busy};
            wait_state <= 1'h0;
        end
    end
endmodule : dtd_bus_model

/* File: testbench/dtd_top_bench.sv */
// Self-checking bench for the data-transfer timing engine.
`timescale 1ns/1ps
module dtd_top_bench;
    // =========================================================================
    // Signals
    // =========================================================================
    typedef struct packed {
        logic [23:0] op;
        logic [6:0]  f;
        logic [3:0]  w;
        logic [5:0]  clk;
        logic [2:0]  cyc;
    } dtd_row_t;
    logic                CLK = 1'h0;
    logic                RSTN = 1'h0;
    logic                FLOAT_REQUEST = 1'h0;
    logic                HOLD_ACK_INT = 1'h0;
    logic                ISSUE = 1'h0;
    dtd_pkg::dtd_instr_t INSTR = '0;
    logic [15:0]         SEL;
    logic [31:0]         OFFSET = 32'h0;
    logic [23:0]         SEG_BASE = 24'h0;
    logic                WAIT_STATE;
    logic                READY, DONE, FAULT, PROTECTED_MODE, PIN_OE;
    logic                HOLD_ACKNOWLEDGE, HOLD_ACKNOWLEDGE_OE;
    logic [5:0]          CLOCKS_USED;
    logic [2:0]          DATA_CYCLES;
    logic [23:0]         PHYS_ADDR;
    logic [3:0]          waits = 4'h0;
    int                  n_fail = 0;
    int                  n_checks = 0;
    // Flags: {code16, v86, two_reg, slow_io, odd, size}; a cycle count of 7 is not compared.
    dtd_row_t rows[30] = '{
        '{24'h89c000, 7'h00, 4'h0, 6'h02, 3'h0}, '{24'h890000, 7'h00, 4'h0, 6'h02, 3'h1},
        '{24'h890400, 7'h10, 4'h0, 6'h03, 3'h1}, '{24'h8bc000, 7'h00, 4'h0, 6'h02, 3'h0},
        '{24'h8b0000, 7'h00, 4'h0, 6'h04, 3'h1}, '{24'h8b0000, 7'h05, 4'h0, 6'h06, 3'h1},
        '{24'h8b0000, 7'h02, 4'h0, 6'h06, 3'h1}, '{24'h8b0000, 7'h06, 4'h0, 6'h08, 3'h1},
        '{24'h870000, 7'h06, 4'h0, 6'h0d, 3'h2}, '{24'h870000, 7'h05, 4'h0, 6'h09, 3'h2},
        '{24'h87c000, 7'h00, 4'h0, 6'h03, 3'h0}, '{24'h870000, 7'h00, 4'h0, 6'h05, 3'h2},
        '{24'hb81234, 7'h00, 4'h0, 6'h02, 3'h7}, '{24'ha30010, 7'h00, 4'h0, 6'h02, 3'h1},
        '{24'h8ed800, 7'h00, 4'h0, 6'h16, 3'h0}, '{24'h8e1800, 7'h00, 4'h0, 6'h17, 3'h6},
        '{24'h0fbfc0, 7'h00, 4'h0, 6'h03, 3'h0}, '{24'h0fb600, 7'h00, 4'h0, 6'h06, 3'h1},
        '{24'h1e0000, 7'h00, 4'h0, 6'h04, 3'h2}, '{24'h1f0000, 7'h00, 4'h0, 6'h19, 3'h6},
        '{24'he41000, 7'h00, 4'h0, 6'h06, 3'h1}, '{24'he41000, 7'h08, 4'h0, 6'h1a, 3'h1},
        '{24'he61000, 7'h00, 4'h0, 6'h04, 3'h1}, '{24'he61000, 7'h08, 4'h0, 6'h18, 3'h1},
        '{24'h8d0000, 7'h00, 4'h0, 6'h02, 3'h0}, '{24'h8b0000, 7'h00, 4'h3, 6'h07, 3'h1},
        '{24'h880000, 7'h02, 4'h0, 6'h02, 3'h1}, '{24'h8d0400, 7'h10, 4'h0, 6'h03, 3'h0},
        '{24'h89c000, 7'h20, 4'h0, 6'h01, 3'h7}, '{24'h89c000, 7'h40, 4'h0, 6'h01, 3'h7}};
    // =========================================================================
    // Design, partner and clock
    // =========================================================================
    dtd_top uut (.CLK, .RSTN, .FLOAT_REQUEST, .HOLD_ACK_INT, .ISSUE, .INSTR, .SEL, .OFFSET,
        .SEG_BASE, .WAIT_STATE, .READY, .DONE, .FAULT, .PROTECTED_MODE, .CLOCKS_USED,
        .DATA_CYCLES, .PHYS_ADDR, .PIN_OE, .HOLD_ACKNOWLEDGE, .HOLD_ACKNOWLEDGE_OE);
    dtd_bus_model u_bus (.clk(CLK), .rstn(RSTN), .busy(!READY), .waits(waits), .sel(SEL),
        .wait_state(WAIT_STATE));
    always #25 CLK = ~CLK;
    // =========================================================================
    // Tasks
    // =========================================================================
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    // Issues one instruction and counts cycles until it completes, faults or 64 have passed.
    task automatic run(input dtd_row_t r, output int k);
        k = 0;
        @(posedge CLK);
        ISSUE <= 1'h1;
        INSTR <= '{r.op[23:16], r.op[15:8], r.op[7:0], r.f[4],
                   dtd_pkg::dtd_size_t'(r.f[1:0]), r.f[2], r.f[3], r.f[5], r.f[6]};
        OFFSET <= {8'h5a, r.op};
        SEG_BASE <= r.op ^ 24'h0f0f0f;
        waits <= r.w;
        @(posedge CLK);
        ISSUE <= 1'h0;
        do begin
            @(negedge CLK);
            k++;
        end while (k < 64 && DONE !== 1'h1 && FAULT !== 1'h1);
    endtask : run
    // =========================================================================
    // Sequence
    // =========================================================================
    initial begin
        #(3000 * 50);
        n_fail++;
        end_of_test();
    end
    initial begin
        int k;
        repeat (3) @(posedge CLK);
        RSTN <= 1'h1;
        @(negedge CLK);
        chk(PROTECTED_MODE, 1, "mode after reset");
        chk(READY, 1, "ready after reset");
        foreach (rows[i]) begin
            run(rows[i], k);
            chk(k, rows[i].clk, "clock count");
            chk(FAULT, rows[i].f[6] | rows[i].f[5], "fault flag");
            if (!(rows[i].f[6] | rows[i].f[5])) begin
                chk(CLOCKS_USED, rows[i].clk, "clocks used");
                chk(PHYS_ADDR, 24'(rows[i].op + (rows[i].op ^ 24'h0f0f0f)), "address");
                if (rows[i].cyc != 3'h7) chk(DATA_CYCLES, rows[i].cyc, "data cycles");
            end
            $display("row %0d done", i);
        end
        // Float: pins released and issue ignored until the request drops.
        @(posedge CLK);
        FLOAT_REQUEST <= 1'h1;
        HOLD_ACK_INT <= 1'h1;
        repeat (3) @(posedge CLK);
        @(negedge CLK);
        chk(PIN_OE, 0, "pins driven in float");
        chk(HOLD_ACKNOWLEDGE_OE, 0, "hold ack driven in float");
        run(rows[0], k);
        chk(k, 64, "issue taken in float");
        @(posedge CLK);
        FLOAT_REQUEST <= 1'h0;
        repeat (3) @(posedge CLK);
        @(negedge CLK);
        chk(PIN_OE, 1, "pins not restored");
        chk(HOLD_ACKNOWLEDGE, 1, "hold ack value");
        $display("float test done");
        // A reset in mid-instruction must abandon it and come back in protected mode.
        @(posedge CLK);
        ISSUE <= 1'h1;
        INSTR <= '{8'h1f, 8'h00, 8'h00, 1'h0, dtd_pkg::DTD_SZ_BYTE, 1'h0, 1'h0, 1'h0, 1'h0};
        @(posedge CLK);
        ISSUE <= 1'h0;
        repeat (4) @(posedge CLK);
        RSTN <= 1'h0;
        @(posedge CLK);
        RSTN <= 1'h1;
        @(negedge CLK);
        chk(PROTECTED_MODE, 1, "mode after second reset");
        chk(READY, 1, "busy after second reset");
        chk(CLOCKS_USED, 0, "count after second reset");
        run(rows[0], k);
        chk(k, 2, "move after second reset");
        $display("reset test done");
        end_of_test();
    end
endmodule : dtd_top_bench
